//--- sewr_core.sv
// Serial EEPROM command sequencer with self-timed write and status output
`timescale 1ns/10ps
`default_nettype none
module sewr_core
    import sewr_pkg::*;
#(
    parameter int unsigned WRITE_CNT  = WRITE_CYCLES,
    parameter int unsigned STATUS_CNT = STATUS_CYCLES
)(
    input  wire logic CLK,
    input  wire logic SYS_RST,
    input  wire logic SCK_N,
    input  wire logic CS_N,
    input  wire logic RESET,
    input  wire logic SERIAL_IN,
    output var  logic DATA_OUT,
    output var  logic DATA_OE,
    output var  logic READY
);
    sewr_tick_if tk ();

    // Two-stage synchronisers for the pins
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic       sck_d_r;
    logic       cs_d_r;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s1_r    <= 4'hf;
            s2_r    <= 4'hf;
            sck_d_r <= 1'b1;
            cs_d_r  <= 1'b1;
        end else begin
            s1_r    <= {SCK_N, CS_N, RESET, SERIAL_IN};
            s2_r    <= s1_r;
            sck_d_r <= s2_r[3];
            cs_d_r  <= s2_r[2];
        end
    end

    logic sck;
    logic cs_n;
    logic rst_pin;
    logic din;
    logic rise;
    logic fall;
    logic cs_fall;
    assign sck     = s2_r[3];
    assign cs_n    = s2_r[2];
    assign rst_pin = s2_r[1];
    assign din     = s2_r[0];
    assign rise    = sck && !sck_d_r;
    assign fall    = !sck && sck_d_r;
    assign cs_fall = !cs_n && cs_d_r;

    // Sequencer state
    sewr_seq_type      st_r,   st_nxt;
    logic [5:0]        bit_r,  bit_nxt;
    logic [7:0]        cmd_r,  cmd_nxt;
    logic [7:0]        adr_r,  adr_nxt;
    logic [DATA_W-1:0] dat_r,  dat_nxt;
    logic              wen_n_r, wen_n_nxt;
    logic              ecc_r;
    logic              out_r,  out_nxt;
    logic              oe_r,   oe_nxt;
    logic              ready_r;
    logic              wr_mem;
    logic [DATA_W-1:0] mem [WORDS];

    // Select status flag from the address byte
    function automatic logic status_bit(input logic [1:0] sel, input logic busy,
                                        input logic wen_n, input logic ecc);
        case (sel)
            SEL_BUSY: status_bit = !busy;
            SEL_WEN:  status_bit = wen_n;
            SEL_ECC:  status_bit = ecc;
            default:  status_bit = 1'b0;
        endcase
    endfunction

    // Next-state logic for command, address, data and output
    always_comb begin
        st_nxt    = st_r;
        bit_nxt   = bit_r;
        cmd_nxt   = cmd_r;
        adr_nxt   = adr_r;
        dat_nxt   = dat_r;
        wen_n_nxt = wen_n_r;
        out_nxt   = out_r;
        oe_nxt    = oe_r;
        tk.start  = 1'b0;
        tk.abort  = rst_pin;
        wr_mem    = 1'b0;
        if (rst_pin) begin
            st_nxt  = ST_CMD;
            bit_nxt = 6'h0;
            oe_nxt  = 1'b0;
        end else if (cs_n || cs_fall || tk.seq_reset) begin
            st_nxt  = ST_CMD;
            bit_nxt = 6'h0;
            if (cs_n) begin
                oe_nxt = 1'b0;
            end
        end else if (rise) begin
            bit_nxt = bit_r + 6'h1;
            case (st_r)
                ST_CMD: begin
                    cmd_nxt = {cmd_r[6:0], din};
                    if (bit_r + 6'h1 == BIT_CMD_DONE) begin
                        st_nxt = ST_ADDR;
                        if (tk.busy && {cmd_r[6:0], din} != CMD_STATUS) begin
                            st_nxt = ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    adr_nxt = {din, adr_r[7:1]};
                    if (bit_r + 6'h1 == BIT_ADDR_DONE) begin
                        st_nxt = ST_DATA;
                        if (cmd_r == CMD_STATUS) begin
                            st_nxt = ST_STATUS;
                            oe_nxt = 1'b1;
                            // First two address bits, shifted to the bottom, pick the flag
                            out_nxt = status_bit({adr_nxt[0], adr_nxt[1]}, tk.busy,
                                                 wen_n_r, ecc_r);
                        end else if (cmd_r == CMD_WRITE_EN) begin
                            wen_n_nxt = 1'b0;
                            st_nxt = ST_IGNORE;
                        end else if (cmd_r == WRITE_LOCK_CMD) begin
                            wen_n_nxt = 1'b1;
                            st_nxt = ST_IGNORE;
                        end else if (cmd_r == CMD_READ) begin
                            st_nxt = ST_READ;
                            dat_nxt = mem[adr_nxt[ADDR_W-1:0]];
                            oe_nxt = 1'b1;
                        end else if (cmd_r != CMD_WRITE) begin
                            st_nxt = ST_IGNORE;
                        end
                    end
                end
                ST_DATA: begin
                    dat_nxt = {din, dat_r[DATA_W-1:1]};
                    if (bit_r + 6'h1 == BIT_WRITE_EDGE) begin
                        st_nxt = ST_IGNORE;
                        if (!wen_n_r) begin
                            tk.start = 1'b1;
                            wr_mem   = 1'b1;
                        end
                    end
                end
                ST_STATUS: begin
                    out_nxt = status_bit({adr_r[0], adr_r[1]}, tk.busy,
                                         wen_n_r, ecc_r);
                end
                default: begin
                end
            endcase
        end else if (fall && st_r == ST_READ) begin
            out_nxt = dat_r[0];
            dat_nxt = {1'b0, dat_r[DATA_W-1:1]};
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_r    <= ST_CMD;
            bit_r   <= 6'h0;
            cmd_r   <= 8'h0;
            adr_r   <= 8'h0;
            dat_r   <= '0;
            wen_n_r <= 1'b1;
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
            ready_r <= 1'b1;
            ecc_r   <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            bit_r   <= bit_nxt;
            cmd_r   <= cmd_nxt;
            adr_r   <= adr_nxt;
            dat_r   <= dat_nxt;
            wen_n_r <= wen_n_nxt;
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
            ready_r <= !tk.busy;
            ecc_r   <= 1'b0;
        end
    end

    // Storage array written when the write starts
    always_ff @(posedge CLK) begin
        if (wr_mem) begin
            mem[adr_r[ADDR_W-1:0]] <= {din, dat_r[DATA_W-1:1]};
        end
    end

    assign DATA_OUT = out_r;
    assign DATA_OE  = oe_r;
    assign READY    = ready_r;

    sewr_timer #(.WRITE_CNT(WRITE_CNT), .STATUS_CNT(STATUS_CNT)) u_timer (
        .clk (CLK),
        .rst (SYS_RST),
        .tk  (tk)
    );

    property p_start_locked;
        @(posedge CLK) disable iff (SYS_RST)
        tk.start |-> !wen_n_r;
    endproperty
    a_start_locked: assert property (p_start_locked) else $error("write while locked");
    property p_start_edge;
        @(posedge CLK) disable iff (SYS_RST)
        tk.start |-> rise && bit_r == BIT_WRITE_EDGE - 6'h1 && !tk.busy;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("write start off edge");
    property p_status_oe;
        @(posedge CLK) disable iff (SYS_RST)
        (st_r == ST_STATUS && !cs_n && !rst_pin) |=> oe_r;
    endproperty
    a_status_oe: assert property (p_status_oe) else $error("status output dropped");
    property p_cs_release;
        @(posedge CLK) disable iff (SYS_RST)
        cs_n |=> !oe_r;
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("output held after select");
    property p_reset_abort;
        @(posedge CLK) disable iff (SYS_RST)
        rst_pin |=> !tk.busy ##1 ready_r;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");
    property p_ready_flag;
        @(posedge CLK) disable iff (SYS_RST)
        tk.busy |=> !ready_r;
    endproperty
    a_ready_flag: assert property (p_ready_flag) else $error("ready during write");
    property p_busy_only_status;
        @(posedge CLK) disable iff (SYS_RST)
        (tk.busy && st_r == ST_CMD && rise && bit_r == BIT_CMD_DONE - 6'h1
         && {cmd_r[6:0], din} != CMD_STATUS && !cs_n && !cs_fall
         && !rst_pin && !tk.seq_reset)
        |=> st_r == ST_IGNORE;
    endproperty
    a_busy_only_status: assert property (p_busy_only_status) else $error("command taken");
    property p_seq_reset;
        @(posedge CLK) disable iff (SYS_RST)
        (tk.seq_reset && !rst_pin) |=> st_r == ST_CMD && bit_r == 6'h0;
    endproperty
    a_seq_reset: assert property (p_seq_reset) else $error("no sequencer reset");
    property p_status_enter;
        @(posedge CLK) disable iff (SYS_RST)
        $rose(st_r == ST_STATUS) |-> oe_r && $past(bit_r) == BIT_STATUS_EDGE - 6'h1;
    endproperty
    a_status_enter: assert property (p_status_enter) else $error("status late");
    c_write:  cover property (@(posedge CLK) tk.start);
    c_status: cover property (@(posedge CLK) st_r == ST_STATUS && tk.busy);
    c_abort:  cover property (@(posedge CLK) tk.busy && rst_pin);
endmodule
`default_nettype wire

//--- sewr_host_model.sv
// Host controller model driving clock, select, reset and data pins
`timescale 1ns/10ps
`default_nettype none
module sewr_host_model #(
    parameter int HALF = 45,
    parameter int GAP  = 400
)(
    input  wire logic clk,
    output var  logic sck_n,
    output var  logic cs_n,
    output var  logic reset,
    output var  logic serial_in
);
    logic tied  = 1'b0;
    logic rst_r = 1'b0;
    int   cyc   = 0;
    int   rise_cyc;
    int   nbits;
    initial begin
        sck_n = 1'b1;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // Reset pin either driven alone or wired to select
    assign reset = tied ? cs_n : rst_r;
    // Free-running cycle count for timing checks
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    // Select the device from the idle state
    task automatic open_frame();
        @(negedge clk);
        cs_n = 1'b0;
        nbits = 0;
        repeat (100) @(negedge clk);
    endtask
    // Shift n bits, top bit first; clock idles high between bits
    task automatic send(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            if (nbits > 0 && nbits % 8 == 0)
                repeat (GAP) @(negedge clk);
            sck_n = 1'b0;
            serial_in = v[i];
            repeat (HALF) @(negedge clk);
            sck_n = 1'b1;
            rise_cyc = cyc;
            nbits++;
            repeat (HALF) @(negedge clk);
            serial_in = ~v[i];
        end
    endtask
    // Release select only after the hold time from the last rise
    task automatic close_frame();
        repeat (GAP) @(negedge clk);
        cs_n = 1'b1;
        repeat (GAP) @(negedge clk);
    endtask
    // Drive the separate reset pin
    task automatic set_reset(input logic v);
        @(negedge clk);
        rst_r = v;
    endtask
endmodule
`default_nettype wire

//--- sewr_pkg.sv
// Constants and types shared by the serial EEPROM write sequencer
package sewr_pkg;
    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned WRITE_TIME_MS      = 15;
    localparam int unsigned STATUS_DELAY_US    = 12;
    localparam int unsigned WRITE_CYCLES       = WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned STATUS_CYCLES      = STATUS_DELAY_US * CLK_MHZ;
    localparam logic [7:0]  CMD_READ           = 8'ha8;
    localparam logic [7:0]  CMD_WRITE          = 8'ha4;
    localparam logic [7:0]  CMD_WRITE_EN       = 8'ha3;
    localparam logic [7:0]  WRITE_LOCK_CMD     = 8'ha0;
    localparam logic [7:0]  CMD_STATUS         = 8'ha9;
    localparam logic [1:0]  SEL_BUSY           = 2'h0;
    localparam logic [1:0]  SEL_WEN            = 2'h2;
    localparam logic [1:0]  SEL_ECC            = 2'h1;
    localparam logic [5:0]  BIT_STATUS_EDGE    = 6'h10;
    localparam logic [5:0]  BIT_WRITE_EDGE     = 6'h20;
    localparam logic [5:0]  BIT_ADDR_DONE      = 6'h10;
    localparam logic [5:0]  BIT_CMD_DONE       = 6'h08;
    localparam int unsigned ADDR_W             = 7;
    localparam int unsigned DATA_W             = 16;
    localparam int unsigned WORDS              = 128;
    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_DATA, ST_STATUS, ST_READ, ST_IGNORE
    } sewr_seq_type;
endpackage

//--- sewr_tick_if.sv
// Carrier of write timer start and completion signals
`timescale 1ns/10ps
`default_nettype none
interface sewr_tick_if;
    logic start;
    logic abort;
    logic busy;
    logic seq_reset;
    modport seq   (output start, output abort, input busy, input seq_reset);
    modport timer (input start, input abort, output busy, output seq_reset);
endinterface
`default_nettype wire

//--- sewr_timer.sv
// Self-timed write duration and sequencer reset pulse timer
`timescale 1ns/10ps
`default_nettype none
module sewr_timer
    import sewr_pkg::*;
#(
    parameter int unsigned WRITE_CNT  = WRITE_CYCLES,
    parameter int unsigned STATUS_CNT = STATUS_CYCLES
)(
    input  wire logic     clk,
    input  wire logic     rst,
    sewr_tick_if.timer    tk
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        busy_r;
    logic        busy_nxt;

    // Count write time; drop busy at end or on abort
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        if (tk.abort) begin
            busy_nxt = 1'b0;
            cnt_nxt  = 32'h0;
        end else if (tk.start && !busy_r) begin
            busy_nxt = 1'b1;
            cnt_nxt  = 32'h0;
        end else if (busy_r) begin
            cnt_nxt = cnt_r + 32'h1;
            if (cnt_r >= WRITE_CNT - 1) begin
                busy_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 32'h0;
            busy_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign tk.busy      = busy_r;
    assign tk.seq_reset = busy_r && (cnt_r == STATUS_CNT - 1);

    property p_write_bounded;
        @(posedge clk) disable iff (rst)
        (busy_r && cnt_r == WRITE_CNT - 1 && !tk.abort) |=> !busy_r;
    endproperty
    a_write_bounded: assert property (p_write_bounded) else $error("write overran");
endmodule
`default_nettype wire

//--- tb_serial_eeprom_write_sequencing.sv
// Self-checking bench of the serial EEPROM write sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_eeprom_write_sequencing;
    import sewr_pkg::*;
    localparam int WCNT = 10000;
    localparam int SCNT = 1200;
    localparam logic [15:0] POLL_WORD = 16'hbeef;
    logic clk     = 1'b0;
    logic sys_rst = 1'b1;
    logic sck_n, cs_n, reset, serial_in, data_out, data_oe, ready;
    int   err_count   = 0;
    int   check_count = 0;
    int   t0;
    always #5 clk = ~clk;
    sewr_host_model host (.clk(clk), .sck_n(sck_n), .cs_n(cs_n), .reset(reset),
        .serial_in(serial_in));
    sewr_core #(.WRITE_CNT(WCNT), .STATUS_CNT(SCNT)) DUT (.CLK(clk), .SYS_RST(sys_rst),
        .SCK_N(sck_n), .CS_N(cs_n), .RESET(reset), .SERIAL_IN(serial_in),
        .DATA_OUT(data_out), .DATA_OE(data_oe), .READY(ready));
    // Print verdict and stop
    task automatic results();
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wait_until(input int t);
        while (host.cyc < t) @(negedge clk);
    endtask
    // Address and data fields travel least significant bit first
    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            rev8[i] = v[7 - i];
    endfunction
    function automatic logic [15:0] rev16(input logic [15:0] v);
        rev16 = {rev8(v[7:0]), rev8(v[15:8])};
    endfunction
    // Status frame; fresh opens a new select window first
    task automatic status(input bit fresh, input logic [1:0] sel, input logic exp);
        if (fresh)
            host.open_frame();
        host.send({CMD_STATUS, sel, 5'h00}, 15);
        `CHK("oe_before_16th", 1'b0, data_oe)
        host.send(16'h0000, 1);
        `CHK("status_oe", 1'b1, data_oe)
        `CHK("status_value", exp, data_out)
        host.send(16'h00ff, 8);
        `CHK("status_hold", exp, data_out)
        `CHK("status_oe_hold", 1'b1, data_oe)
        host.close_frame();
        `CHK("oe_after_cs", 1'b0, data_oe)
    endtask
    task automatic cmd(input logic [7:0] c);
        host.open_frame();
        host.send({c, 8'h00}, 16);
        host.close_frame();
    endtask
    // Write frame left open at the 32nd rise
    task automatic write_frame(input logic [15:0] d);
        host.open_frame();
        host.send({CMD_WRITE, rev8(8'h05)}, 16);
        host.send(rev16(d), 16);
        t0 = host.rise_cyc;
    endtask
    task automatic t_reset_state();
        `CHK("ready_rst", 1'b1, ready)
        `CHK("oe_rst", 1'b0, data_oe)
        status(1, SEL_BUSY, 1'b1);
        status(1, SEL_WEN, 1'b1);
        status(1, SEL_ECC, 1'b0);
    endtask
    task automatic t_locked_write();
        write_frame(16'h1234);
        repeat (20) @(negedge clk);
        `CHK("locked_ready", 1'b1, ready)
        host.close_frame();
        cmd(CMD_WRITE_EN);
        status(1, SEL_WEN, 1'b0);
        cmd(WRITE_LOCK_CMD);
        status(1, SEL_WEN, 1'b1);
        cmd(CMD_WRITE_EN);
    endtask
    // Write, poll status with select still low, refuse a read
    task automatic t_write_poll();
        write_frame(POLL_WORD);
        `CHK("write_start", 1'b0, ready)
        wait_until(t0 + SCNT + 10);
        status(0, SEL_BUSY, 1'b0);
        host.open_frame();
        host.send({CMD_READ, 8'h05}, 16);
        host.send(16'h0000, 8);
        `CHK("read_refused", 1'b0, data_oe)
        host.close_frame();
        wait_until(t0 + WCNT - 10);
        `CHK("busy_late", 1'b0, ready)
        wait_until(t0 + WCNT + 10);
        `CHK("write_done", 1'b1, ready)
        status(1, SEL_BUSY, 1'b1);
    endtask
    // Read back the polled word; one data bit appears per clock fall
    task automatic t_read_back();
        host.open_frame();
        host.send({CMD_READ, rev8(8'h05)}, 16);
        `CHK("read_oe", 1'b1, data_oe)
        for (int i = 0; i < DATA_W; i++) begin
            host.send(16'h0000, 1);
            `CHK("read_bit", POLL_WORD[i], data_out)
        end
        host.close_frame();
        `CHK("read_oe_off", 1'b0, data_oe)
    endtask
    // Reset pin raised in mid-write stops it
    task automatic t_abort();
        write_frame(16'h0f0f);
        `CHK("abort_busy", 1'b0, ready)
        repeat (200) @(negedge clk);
        host.set_reset(1'b1);
        repeat (10) @(negedge clk);
        `CHK("abort_ready", 1'b1, ready)
        host.set_reset(1'b0);
        host.close_frame();
        cmd(CMD_WRITE_EN);
    endtask
    // Select tied to reset; dummy bit keeps status mode off
    task automatic t_tied();
        host.tied = 1'b1;
        write_frame(16'ha5a5);
        `CHK("tied_busy", 1'b0, ready)
        wait_until(t0 + SCNT + 10);
        host.send(16'h0000, 1);
        host.send(16'h5555, 16);
        `CHK("dummy_no_status", 1'b0, data_oe)
        `CHK("dummy_busy", 1'b0, ready)
        wait_until(t0 + WCNT + 10);
        `CHK("tied_done", 1'b1, ready)
        host.close_frame();
        host.tied = 1'b0;
    endtask
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        t_reset_state();
        t_locked_write();
        t_write_poll();
        t_read_back();
        t_abort();
        t_tied();
        results();
    end
    // Hang guard
    initial begin
        repeat (100000) @(negedge clk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
